// File: verilog/elrb_pkg.sv
// elrb_pkg: constants, register map and record layout for the event log ring buffer
// assumes one system clock; used by elrb_top and the testbench
package elrb_pkg;
  localparam int ELRB_ADDR_W = 8;
  localparam int ELRB_DATA_W = 32;
  localparam int ELRB_PTR_W = 11;
  localparam int ELRB_CHAN_W = 8;
  localparam int ELRB_CODE_W = 8;
  localparam int ELRB_SRC_W = 16;
  localparam int ELRB_DEPTH_MAX = 2000;
  localparam int ELRB_DEPTH_MIN = 50;
  localparam logic [10:0] ELRB_DEPTH_RESET = 11'h0C8;
  localparam logic [10:0] ELRB_DEPTH_LO = 11'h032;
  localparam logic [10:0] ELRB_DEPTH_HI = 11'h7D0;
  // register byte offsets
  localparam logic [7:0] ELRB_REG_CONTROL = 8'h00;
  localparam logic [7:0] ELRB_REG_DEPTH = 8'h04;
  localparam logic [7:0] ELRB_REG_COUNT = 8'h08;
  localparam logic [7:0] ELRB_REG_EVMASK = 8'h0C;
  localparam logic [7:0] ELRB_REG_READ_LO = 8'h10;
  localparam logic [7:0] ELRB_REG_READ_HI = 8'h14;
  localparam logic [7:0] ELRB_REG_PEEK_LO = 8'h18;
  localparam logic [7:0] ELRB_REG_PEEK_HI = 8'h1C;
  localparam logic [7:0] ELRB_REG_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ELRB_REG_IRQ_MASK = 8'h24;
  // control bit positions
  localparam int ELRB_CTL_CLEAR = 0;
  localparam int ELRB_CTL_ORDER = 1;
  localparam int ELRB_CTL_SCALE = 2;
  localparam int ELRB_CTL_POPUP = 3;
  localparam logic [3:0] ELRB_CONTROL_RESET = 4'h0;
  // irq bit positions
  localparam int ELRB_IRQ_NEW = 0;
  localparam int ELRB_IRQ_OVR = 1;
  localparam int ELRB_IRQ_W = 2;
  // scale select codes
  localparam logic ELRB_SCALE_PER_UNIT = 1'b0;
  localparam logic ELRB_SCALE_PRIMARY = 1'b1;
  // time stamp: days since epoch, milliseconds of day
  typedef struct packed {
    logic [15:0] day;
    logic [26:0] msec;
  } elrb_stamp_type;
  typedef struct packed {
    logic [7:0] event_channel_field;
    logic [7:0] event_code_field;
  } elrb_id_type;
  typedef struct packed {
    logic overrun_marker;
    logic time_synced;
    logic scale_primary;
    elrb_id_type id;
    elrb_stamp_type stamp;
  } elrb_record_type;
  localparam int ELRB_REC_W = $bits(elrb_record_type);
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } elrb_bus_type;
endpackage : elrb_pkg

// File: verilog/elrb_mem.sv
// elrb_mem: simple dual port record store with registered read data
// assumes write and read on the same clock; read data valid one cycle after address
`timescale 1ns/1ps
module elrb_mem #(
  parameter int WIDTH = 62,
  parameter int DEPTH = 2000,
  parameter int AW = 11
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] store [0:DEPTH-1];

  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("elrb_mem depth exceeds address range");
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= store[raddr];
  end
endmodule : elrb_mem

// File: verilog/elrb_top.sv
// elrb_top: circular event log with masking, overwrite, overrun marker and register port
// assumes producers, reader and register master share CLK; one event per cycle at most
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module elrb_top
  import elrb_pkg::*;
#(
  parameter int SOURCES = 16
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic EVENT_VALID,
  input wire logic [3:0] EVENT_SOURCE,
  input wire elrb_pkg::elrb_id_type EVENT_ID,
  input wire elrb_pkg::elrb_stamp_type EVENT_STAMP,
  input wire logic TIME_SYNCED,
  input wire elrb_pkg::elrb_bus_type BUS,
  output logic [31:0] RDATA,
  output logic DISPLAY_NEWEST_FIRST,
  output logic FAULT_VALUE_SCALING_SELECT,
  output logic POPUP,
  output logic IRQ
);
  import elrb_pkg::*;

  initial begin
    if (SOURCES < 1 || SOURCES > ELRB_SRC_W) begin
      $error("elrb_top sources out of range");
    end
  end

  typedef enum logic [1:0] {
    ELRB_RD_IDLE_type = 2'b01,
    ELRB_RD_WAIT_type = 2'b10
  } elrb_rdstate_type;

  logic [10:0] depth;
  logic [10:0] count;
  logic [10:0] unread;
  logic [10:0] wptr;
  logic [10:0] rptr;
  logic [10:0] last_ptr;
  logic [15:0] event_mask;
  logic display_order;
  logic scale_sel;
  logic popup_enable;
  logic [ELRB_IRQ_W-1:0] irq_status;
  logic [ELRB_IRQ_W-1:0] irq_mask;
  logic pending_overrun;
  logic accept;
  logic overwrite_unread;
  logic clear_req;
  logic depth_change;
  logic [10:0] mem_raddr;
  logic [ELRB_REC_W-1:0] mem_rdata;
  elrb_record_type new_record;
  elrb_record_type head_rec;
  elrb_record_type hi_rec;
  elrb_record_type newest_rec;
  elrb_record_type fwd_rec;
  logic fwd_valid;
  logic [10:0] next_rptr;
  logic [31:0] next_rdata;
  logic [10:0] wdepth;

  function automatic logic [10:0] elrb_wrap(input logic [10:0] p, input logic [10:0] d);
    if (p + 11'h001 >= d) begin
      return 11'h000;
    end
    return p + 11'h001;
  endfunction : elrb_wrap

  function automatic logic is_reg(input elrb_bus_type b, input logic [7:0] off);
    return b.addr == off;
  endfunction : is_reg

  function automatic logic [31:0] hi_word(input elrb_record_type r);
    return {r.overrun_marker, r.time_synced, r.scale_primary, 2'b00, r.stamp.msec};
  endfunction : hi_word

  assign wdepth = BUS.wdata[10:0];
  assign depth_change = BUS.wr && is_reg(BUS, ELRB_REG_DEPTH) && wdepth >= ELRB_DEPTH_LO &&
                        wdepth <= ELRB_DEPTH_HI && wdepth != depth;
  assign clear_req = BUS.wr && is_reg(BUS, ELRB_REG_CONTROL) && BUS.wdata[ELRB_CTL_CLEAR];
  assign accept = EVENT_VALID && !event_mask[EVENT_SOURCE] && !clear_req && !depth_change;
  assign overwrite_unread = accept && count == depth && unread == depth;

  always_comb begin
    new_record.id = EVENT_ID;
    new_record.stamp = EVENT_STAMP;
    new_record.time_synced = TIME_SYNCED;
    new_record.scale_primary = scale_sel;
    new_record.overrun_marker = overwrite_unread || pending_overrun;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      depth <= ELRB_DEPTH_RESET;
    end else if (depth_change) begin
      depth <= wdepth;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wptr <= 11'h000;
      count <= 11'h000;
      last_ptr <= 11'h000;
    end else if (clear_req || depth_change) begin
      wptr <= 11'h000;
      count <= 11'h000;
      last_ptr <= 11'h000;
    end else if (accept) begin
      last_ptr <= wptr;
      wptr <= elrb_wrap(wptr, depth);
      if (count != depth) begin
        count <= count + 11'h001;
      end
    end
  end

  logic poll_read;
  assign poll_read = BUS.rd && is_reg(BUS, ELRB_REG_READ_LO) && unread != 11'h000;

  // read pointer known one edge early so the store prefetches the head
  always_comb begin
    next_rptr = rptr;
    if (clear_req || depth_change) begin
      next_rptr = 11'h000;
    end else if (poll_read || overwrite_unread) begin
      next_rptr = elrb_wrap(rptr, depth);
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rptr <= 11'h000;
      unread <= 11'h000;
    end else if (clear_req || depth_change) begin
      rptr <= 11'h000;
      unread <= 11'h000;
    end else begin
      rptr <= next_rptr;
      if (accept && !poll_read && unread != depth) begin
        unread <= unread + 11'h001;
      end else if (poll_read && !accept) begin
        unread <= unread - 11'h001;
      end
    end
  end

  // pending marker never set; reset, clear, depth change and accept only clear it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pending_overrun <= 1'b0;
    end else if (clear_req || depth_change || accept) begin
      pending_overrun <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      event_mask <= 16'h0000;
      {popup_enable, scale_sel, display_order} <= ELRB_CONTROL_RESET[3:1];
    end else if (BUS.wr) begin
      if (is_reg(BUS, ELRB_REG_EVMASK)) begin
        event_mask <= BUS.wdata[15:0];
      end
      if (is_reg(BUS, ELRB_REG_CONTROL)) begin
        display_order <= BUS.wdata[ELRB_CTL_ORDER];
        scale_sel <= BUS.wdata[ELRB_CTL_SCALE];
        popup_enable <= BUS.wdata[ELRB_CTL_POPUP];
      end
    end
  end

  // interrupt status: set wins over write-one clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      if (BUS.wr && is_reg(BUS, ELRB_REG_IRQ_MASK)) begin
        irq_mask <= BUS.wdata[ELRB_IRQ_W-1:0];
      end
      irq_status <= (irq_status & ~((BUS.wr && is_reg(BUS, ELRB_REG_IRQ_STATUS)) ?
                    BUS.wdata[ELRB_IRQ_W-1:0] : 2'b00)) | {overwrite_unread, accept};
    end
  end

  // the store holds the oldest unread record ready for a poll, except a record written to that address in the same cycle
  assign mem_raddr = next_rptr;

  // a record written to the prefetch address in the same cycle bypasses the store
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      fwd_valid <= 1'b0;
    end else begin
      fwd_valid <= accept && wptr == next_rptr;
    end
  end

  always_ff @(posedge CLK) begin
    fwd_rec <= new_record;
  end

  assign head_rec = fwd_valid ? fwd_rec : elrb_record_type'(mem_rdata);

  // a poll keeps its record for the high word; peek sees the newest
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hi_rec <= '0;
      newest_rec <= '0;
    end else begin
      if (poll_read) begin
        hi_rec <= head_rec;
      end
      if (accept) begin
        newest_rec <= new_record;
      end
    end
  end

  elrb_mem #(.WIDTH(ELRB_REC_W), .DEPTH(ELRB_DEPTH_MAX), .AW(ELRB_PTR_W)) u_mem (
    .clk(CLK),
    .we(accept),
    .waddr(wptr),
    .wdata(new_record),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // read data registered at the strobe edge, so they stand in the cycle after it
  always_comb begin
    next_rdata = 32'h00000000;
    if (BUS.rd) begin
      unique case (BUS.addr)
        ELRB_REG_CONTROL: next_rdata = {28'h0000000, popup_enable, scale_sel, display_order, 1'b0};
        ELRB_REG_DEPTH: next_rdata = {21'h000000, depth};
        ELRB_REG_COUNT: next_rdata = {5'h00, unread, 5'h00, count};
        ELRB_REG_EVMASK: next_rdata = {16'h0000, event_mask};
        ELRB_REG_READ_LO: next_rdata = {head_rec.id, head_rec.stamp.day};
        ELRB_REG_PEEK_LO: next_rdata = {newest_rec.id, newest_rec.stamp.day};
        ELRB_REG_READ_HI: next_rdata = hi_word(hi_rec);
        ELRB_REG_PEEK_HI: next_rdata = hi_word(newest_rec);
        ELRB_REG_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
        ELRB_REG_IRQ_MASK: next_rdata = {30'h00000000, irq_mask};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 32'h00000000;
      DISPLAY_NEWEST_FIRST <= 1'b0;
      FAULT_VALUE_SCALING_SELECT <= ELRB_SCALE_PER_UNIT;
      POPUP <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      RDATA <= next_rdata;
      DISPLAY_NEWEST_FIRST <= display_order;
      FAULT_VALUE_SCALING_SELECT <= scale_sel;
      POPUP <= accept && popup_enable;
      IRQ <= |(irq_status & irq_mask);
    end
  end
endmodule : elrb_top

// File: tb/elrb_assertions.sv
// elrb_assertions: port-level checks for elrb_top
// assumes one clock, async reset and the one-cycle register strobes
`timescale 1ns/1ps
module elrb_assertions (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic EVENT_VALID,
  input wire logic [3:0] EVENT_SOURCE,
  input wire elrb_pkg::elrb_bus_type BUS,
  input wire logic [31:0] RDATA,
  input wire logic DISPLAY_NEWEST_FIRST,
  input wire logic FAULT_VALUE_SCALING_SELECT,
  input wire logic POPUP,
  input wire logic IRQ
);
  import elrb_pkg::*;
  logic pen;
  logic dw;
  logic [15:0] msk;
  // shadow of popup enable, source mask and depth-written flag
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pen <= 1'b0;
      dw <= 1'b0;
      msk <= 16'h0;
    end else if (BUS.wr) begin
      if (BUS.addr == ELRB_REG_CONTROL) pen <= BUS.wdata[3];
      if (BUS.addr == ELRB_REG_DEPTH) dw <= 1'b1;
      if (BUS.addr == ELRB_REG_EVMASK) msk <= BUS.wdata[15:0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  popup_cause_a: assert property (POPUP |-> $past(EVENT_VALID && pen && !msk[EVENT_SOURCE]))
    else $error("popup without enabled event");
  popup_raise_a: assert property (EVENT_VALID && pen && !msk[EVENT_SOURCE] && !BUS.wr |=> POPUP)
    else $error("accepted event gave no popup");
  rdata_idle_a: assert property (!$past(BUS.rd) |-> RDATA == 32'h0)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (BUS.rd && BUS.addr == 8'hF0 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  depth_default_a: assert property (BUS.rd && BUS.addr == ELRB_REG_DEPTH && !dw |=> RDATA == 32'h000000C8)
    else $error("reset depth wrong");
  order_bit_a: assert property (BUS.wr && BUS.addr == ELRB_REG_CONTROL |=> ##1 DISPLAY_NEWEST_FIRST == $past(BUS.wdata[1], 2))
    else $error("display order not taken");
  scale_bit_a: assert property (BUS.wr && BUS.addr == ELRB_REG_CONTROL |=> ##1 FAULT_VALUE_SCALING_SELECT == $past(BUS.wdata[2], 2))
    else $error("scaling select not taken");
  irq_masked_a: assert property (BUS.wr && BUS.addr == ELRB_REG_IRQ_MASK && BUS.wdata[1:0] == 2'h0 |=> ##1 !IRQ)
    else $error("masked interrupt still high");
  clear_count_a: assert property (BUS.wr && BUS.addr == ELRB_REG_CONTROL && BUS.wdata[0] ##1 !EVENT_VALID
    ##1 BUS.rd && BUS.addr == ELRB_REG_COUNT |=> RDATA == 32'h0)
    else $error("count not zero after clear");
endmodule : elrb_assertions
bind elrb_top elrb_assertions chk_u (.CLK, .RESET, .EVENT_VALID, .EVENT_SOURCE, .BUS, .RDATA,
  .DISPLAY_NEWEST_FIRST, .FAULT_VALUE_SCALING_SELECT, .POPUP, .IRQ);

// File: tb/elrb_poller.sv
// elrb_poller: polling master model driving the register port
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/1ps
module elrb_poller (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output elrb_pkg::elrb_bus_type bus
);
  import elrb_pkg::*;
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic poll(output logic [31:0] lo, output logic [31:0] hi);
    rd(ELRB_REG_READ_LO, lo);
    rd(ELRB_REG_READ_HI, hi);
  endtask : poll
endmodule : elrb_poller

// File: tb/elrb_bench.sv
// elrb_bench: self-checking bench for the event log ring buffer
// assumes elrb_top, elrb_poller and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH %0t %h", $time, a); end end
module elrb_bench;
  import elrb_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ev = 1'b0;
  logic [3:0] src = 4'h0;
  elrb_id_type id = '0;
  elrb_stamp_type st = '0;
  logic sync = 1'b0;
  elrb_bus_type bus;
  logic [31:0] rdata, lo, hi;
  logic order, scale, popup, irq;
  logic [31:0] dv[4] = '{32'h31, 32'h7D1, 32'h7D0, 32'h32};
  logic [31:0] de[4] = '{32'hC8, 32'hC8, 32'h7D0, 32'h32};
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  elrb_top dut_u (.CLK(clk), .RESET(reset), .EVENT_VALID(ev), .EVENT_SOURCE(src), .EVENT_ID(id), .EVENT_STAMP(st),
    .TIME_SYNCED(sync), .BUS(bus), .RDATA(rdata), .DISPLAY_NEWEST_FIRST(order), .FAULT_VALUE_SCALING_SELECT(scale),
    .POPUP(popup), .IRQ(irq));
  elrb_poller host_u (.clk(clk), .rdata(rdata), .bus(bus));
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chkr(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host_u.rd(a, d);
    `CHK(d, e)
  endtask : chkr
  task automatic send(input logic [3:0] s, input logic [15:0] i, input logic [26:0] ms, input logic y);
    @(posedge clk) begin
      ev <= 1'b1;
      src <= s;
      id <= i;
      st <= {16'h1234, ms};
      sync <= y;
    end
    @(posedge clk) ev <= 1'b0;
  endtask : send
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      $display("MISMATCH %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    chkr(ELRB_REG_DEPTH, 32'hC8);
    for (int k = 0; k < 4; k++) begin
      host_u.wr(ELRB_REG_DEPTH, dv[k]);
      chkr(ELRB_REG_DEPTH, de[k]);
    end
    host_u.wr(ELRB_REG_CONTROL, 32'hE);
    repeat (2) @(posedge clk);
    `CHK({order, scale}, 2'h3)
    host_u.wr(ELRB_REG_IRQ_MASK, 32'h3);
    host_u.wr(ELRB_REG_EVMASK, 32'h8);
    send(4'h3, 16'h0102, 27'h14, 1'b1);
    chkr(ELRB_REG_COUNT, 32'h0);
    send(4'h0, 16'h0005, 27'h14, 1'b1);
    chkr(ELRB_REG_COUNT, 32'h00010001);
    `CHK(irq, 1'b1)
    chkr(ELRB_REG_PEEK_HI, 32'h60000014);
    chkr(ELRB_REG_PEEK_HI, 32'h60000014);
    host_u.poll(lo, hi);
    `CHK(lo, 32'h00051234)
    `CHK(hi, 32'h60000014)
    chkr(ELRB_REG_COUNT, 32'h00000001);
    host_u.wr(ELRB_REG_IRQ_STATUS, 32'h1);
    chkr(ELRB_REG_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    host_u.wr(ELRB_REG_CONTROL, 32'h7);
    chkr(ELRB_REG_COUNT, 32'h0);
    host_u.wr(ELRB_REG_IRQ_MASK, 32'h0);
    for (int i = 1; i <= 51; i++) send(4'h1, {8'h01, 8'(i)}, 27'(i), 1'b0);
    chkr(ELRB_REG_COUNT, 32'h00320032);
    chkr(ELRB_REG_PEEK_HI, 32'hA0000033);
    chkr(ELRB_REG_IRQ_STATUS, 32'h3);
    `CHK(irq, 1'b0)
    host_u.poll(lo, hi);
    `CHK(lo, 32'h01021234)
    host_u.wr(ELRB_REG_DEPTH, 32'h7D0);
    chkr(ELRB_REG_COUNT, 32'h0);
    host_u.wr(ELRB_REG_CONTROL, 32'h0);
    send(4'h0, 16'h0107, 27'h5, 1'b1);
    chkr(8'hF0, 32'h0);
    `CHK({order, scale, popup}, 3'h0)
    summarize();
  end
endmodule : elrb_bench
